/* dv/flash_partner.sv */
module flash_partner #(
  parameter logic [31:0] FLASH_STAT = 32'h0000_0a5a
) (
  input  wire logic        sys_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        erase_req_i,
  input  wire logic [31:0] erase_addr_i,
  input  wire logic        drv_req_i,
  input  wire logic        drv_chip_i,
  input  wire logic [31:0] drv_addr_i,
  output logic             erase_done_o,
  output logic             drv_done_o,
  output logic             err_o,
  output logic [31:0]      status_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int          lat       = 0;     // extra cycles a unit takes
  int          fail      = -1;    // unit index that faults, -1 none
  int          n_units   = 0;     // units finished since cleared
  int          wait_q    = 0;     // cycles spent on this unit
  logic        chip_seen = 1'b0;  // a chip-erase call was made
  logic [31:0] addr_log [8];      // unit addresses in order
  // one done pulse per unit; the gap after it lets the address move on
  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      erase_done_o <= 1'b0;
      drv_done_o   <= 1'b0;
      err_o        <= 1'b0;
      status_o     <= 32'h0000_0000;
      wait_q       <= 0;
    end else begin
      erase_done_o <= 1'b0;
      drv_done_o   <= 1'b0;
      err_o        <= 1'b0;
      // status churns outside done so a stale sample is seen
      status_o     <= ~status_o;
      if ((erase_req_i || drv_req_i) && !erase_done_o && !drv_done_o) begin
        if (wait_q < lat) begin
          wait_q <= wait_q + 1;
        end else begin
          wait_q       <= 0;
          erase_done_o <= erase_req_i;
          drv_done_o   <= drv_req_i;  // driver loaded beforehand
          err_o        <= (n_units == fail);
          status_o     <= FLASH_STAT;
          addr_log[n_units[2:0]] <= erase_req_i ? erase_addr_i : drv_addr_i;
          if (drv_req_i && drv_chip_i) chip_seen <= 1'b1;
          n_units <= n_units + 1;
        end
      end
    end
  end
endmodule // flash_partner

/* dv/tb_flash_erase_command_handler.sv */
module tb_flash_erase_command_handler import erase_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
    n_fail++; $display("wrong value %s exp %h got %h", nm, e, g); end end
  localparam logic [31:0] U  = UNUSED_CODE;
  localparam logic [31:0] FS = 32'h0000_0a5a;  // flash fault status
  localparam logic [31:0] A  = 32'h0000_2000;  // plain unit start
  localparam logic [31:0] B  = 32'h0000_2fff;  // plain unit end
  localparam logic [7:0]  T  = TERMINATOR;
  int n_fail = 0;
  int comparisons = 0;
  logic sys_clk_i, resetn_i, rx_valid_i, tx_ready_i, tx_valid_o;
  logic [7:0] rx_data_i, tx_data_o;
  logic [2:0] lifecycle_state_i;
  logic enc_write_no_reset_i, auth_level_zero_i, auth_level_one_i;
  logic [NUM_AREAS-1:0][31:0] area_lo_i, area_hi_i, erase_unit_i;
  logic [NUM_AREAS-1:0][7:0]  area_kind_i;
  logic [31:0] access_lo_i, access_hi_i, secure_lo_i, secure_hi_i;
  logic [31:0] perm_lo_i, perm_hi_i, erase_addr_o, drv_addr_o;
  logic [31:0] flash_status_i;
  logic erase_req_o, erase_done_i, erase_err_i, drv_req_o, drv_chip_o;
  logic drv_done_i, drv_err_i, busy_o;
  assign drv_err_i = erase_err_i;  // one fault line serves both
  flash_erase_command_handler DUT (.*);
  flash_partner #(.FLASH_STAT(FS)) FP (
    .sys_clk_i    (sys_clk_i),
    .resetn_i     (resetn_i),
    .erase_req_i  (erase_req_o),
    .erase_addr_i (erase_addr_o),
    .drv_req_i    (drv_req_o),
    .drv_chip_i   (drv_chip_o),
    .drv_addr_i   (drv_addr_o),
    .erase_done_o (erase_done_i),
    .drv_done_o   (drv_done_i),
    .err_o        (erase_err_i),
    .status_o     (flash_status_i)
  );
  always #2.5 sys_clk_i = ~sys_clk_i;
  // link stalls every other cycle
  always @(posedge sys_clk_i) tx_ready_i <= ~tx_ready_i;
  task automatic conclude;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // one packet out, one reply in; garbage bytes lead every packet
  task automatic run(input logic [31:0] start_location, ead, input logic [7:0] ln,
      sx, last, sts, input logic [31:0] det, loc, input int units);
    logic [7:0] pk[$];
    logic [7:0] ex[$];
    logic [7:0] s;
    int k;
    FP.n_units = 0;
    pk = {8'h55, 8'h03, CMD_START, 8'h00, ln, CMD_ERASE,
          start_location[31:24], start_location[23:16], start_location[15:8], start_location[7:0],
          ead[31:24], ead[23:16], ead[15:8], ead[7:0]};
    while (pk.size() > ln + 5) void'(pk.pop_back());
    s = 8'h00;
    for (k = 3; k < pk.size(); k++) s -= pk[k];
    pk.push_back(s + sx);
    pk.push_back(last);
    foreach (pk[i]) begin
      @(posedge sys_clk_i);
      rx_valid_i <= 1'b1;
      rx_data_i  <= pk[i];
    end
    @(posedge sys_clk_i);
    rx_valid_i <= 1'b0;
    ex = {DATA_START, REPLY_LEN[15:8], REPLY_LEN[7:0],
          (sts === STS_OK) ? CMD_ERASE : RES_ERR, sts,
          det[31:24], det[23:16], det[15:8], det[7:0],
          loc[31:24], loc[23:16], loc[15:8], loc[7:0]};
    s = 8'h00;
    for (k = 1; k < 13; k++) s -= ex[k];
    ex.push_back(s);
    ex.push_back(T);
    k = 0;
    // look mid-cycle: valid, ready and data then hold what the edge takes
    for (int t = 0; t < 3000 && k < 15; t++) begin
      @(negedge sys_clk_i);
      if (tx_valid_o === 1'b1 && tx_ready_i === 1'b1) begin
        `CHK("reply byte", ex[k], tx_data_o)
        k++;
      end
    end
    `CHK("reply count", 15, k)
    if (k != 15) conclude();
    repeat (2) @(negedge sys_clk_i);
    `CHK("busy", 1'b0, busy_o)
    `CHK("units", units, FP.n_units)
  endtask
  task automatic sc_ok;
    run(A, 32'h0000_3fff, 8'h09, 8'h00, T, STS_OK, U, U, 2);
    `CHK("unit 0", 32'h0000_2000, FP.addr_log[0])
    `CHK("unit 1", 32'h0000_3000, FP.addr_log[1])
  endtask
  task automatic sc_frame;
    run(A, B, 8'h09, 8'h01, T, STS_SUM, U, U, 0);
    run(A, B, 8'h09, 8'h00, 8'h04, STS_PACKET, U, U, 0);
    run(A, B, 8'h08, 8'h00, T, STS_PACKET, U, U, 0);
    run(A, B, 8'h00, 8'h00, T, STS_PACKET, U, U, 0);
    run(A, B, 8'h09, 8'h01, 8'h04, STS_PACKET, U, U, 0);
  endtask
  task automatic sc_accept;
    @(posedge sys_clk_i) lifecycle_state_i <= 3'h4;
    run(A, B, 8'h09, 8'h00, T, STS_ACCEPT, U, U, 0);
    run(B, A, 8'h09, 8'h00, T, STS_ACCEPT, U, U, 0);
    @(posedge sys_clk_i) lifecycle_state_i <= 3'h3;
    @(posedge sys_clk_i) enc_write_no_reset_i <= 1'b1;
    run(A, B, 8'h09, 8'h00, T, STS_ACCEPT, U, U, 0);
    @(posedge sys_clk_i) enc_write_no_reset_i <= 1'b0;
  endtask
  task automatic sc_param;
    run(B, A, 8'h09, 8'h00, T, STS_PARAM, U, U, 0);
    run(32'h0002_0000, 32'h0002_0fff, 8'h09, 8'h00, T, STS_PARAM, U, U,
        0);
    run(32'h0000_f000, 32'h0001_0fff, 8'h09, 8'h00, T, STS_PARAM, U, U,
        0);
    run(32'h0001_0000, 32'h0001_00ff, 8'h09, 8'h00, T, STS_PARAM, U, U,
        0);
    run(32'h0000_2100, B, 8'h09, 8'h00, T, STS_PARAM, U, U, 0);
    run(A, 32'h0000_2ffe, 8'h09, 8'h00, T, STS_PARAM, U, U, 0);
  endtask
  task automatic sc_region;
    run(32'h7000_0000, 32'h7000_00ff, 8'h09, 8'h00, T, STS_ADDR, U, U,
        0);
    run(32'h0000_c000, 32'h0000_cfff, 8'h09, 8'h00, T, STS_PROTECT, U, U,
        0);
    @(posedge sys_clk_i) auth_level_one_i <= 1'b1;
    run(32'h0000_a000, 32'h0000_cfff, 8'h09, 8'h00, T, STS_SECURE, U, U,
        0);
    @(posedge sys_clk_i) auth_level_one_i <= 1'b0;
    @(posedge sys_clk_i) auth_level_zero_i <= 1'b1;
    run(A, B, 8'h09, 8'h00, T, STS_SECURE, U, U, 0);
    @(posedge sys_clk_i) auth_level_zero_i <= 1'b0;
  endtask
  task automatic sc_flash;
    FP.fail = 1;
    run(32'h0, B, 8'h09, 8'h00, T, STS_FLASH, FS, 32'h1000, 2);
    FP.fail = 0;
    run(32'h6000_0400, 32'h6000_0bff, 8'h09, 8'h00, T, STS_FLASH, U, U,
        1);
    FP.fail = -1;
  endtask
  task automatic sc_ext;
    FP.lat = 3;
    FP.chip_seen = 1'b0;
    run(32'h6000_0000, 32'h6000_0fff, 8'h09, 8'h00, T, STS_OK, U, U, 1);
    `CHK("chip call", 1'b1, FP.chip_seen)
    FP.chip_seen = 1'b0;
    run(32'h6000_0400, 32'h6000_0bff, 8'h09, 8'h00, T, STS_OK, U, U, 2);
    `CHK("sector call", 1'b0, FP.chip_seen)
    `CHK("sector 1", 32'h6000_0800, FP.addr_log[1])
    FP.lat = 0;
  endtask
  initial begin
    sys_clk_i = 1'b0;
    resetn_i = 1'b0;
    rx_valid_i = 1'b0;
    rx_data_i = 8'h00;
    tx_ready_i = 1'b0;
    lifecycle_state_i = 3'h0;
    enc_write_no_reset_i = 1'b0;
    auth_level_zero_i = 1'b0;
    auth_level_one_i = 1'b0;
    // internal, eau-zero, external area 0, beyond boundary
    area_lo_i = {32'h7000_0000, 32'h6000_0000, 32'h0001_0000, 32'h0};
    area_hi_i = {32'h7000_ffff, 32'h6000_0fff, 32'h0001_ffff, 32'hffff};
    area_kind_i = {8'h03, KIND_EXT, 8'h01, 8'h00};
    erase_unit_i = {32'h100, 32'h400, 32'h0, 32'h1000};
    access_lo_i = 32'h0;
    access_hi_i = 32'h6fff_ffff;
    secure_lo_i = 32'h0000_a000;
    secure_hi_i = 32'h0000_afff;
    perm_lo_i = 32'h0000_c000;
    perm_hi_i = 32'h0000_cfff;
    repeat (3) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    sc_ok();
    sc_frame();
    sc_accept();
    sc_param();
    sc_region();
    sc_flash();
    sc_ext();
    conclude();
  end
endmodule // tb_flash_erase_command_handler

/* hdl/erase_pkg.sv */
package erase_pkg;
  // framing bytes
  localparam logic [7:0]  CMD_START    = 8'h01;
  localparam logic [7:0]  DATA_START   = 8'h81;
  localparam logic [7:0]  TERMINATOR   = 8'h03;
  localparam logic [7:0]  CMD_ERASE    = 8'h12;
  localparam logic [7:0]  RES_ERR      = 8'h92;
  localparam logic [15:0] CMD_LEN      = 16'h0009;
  localparam logic [15:0] REPLY_LEN    = 16'h000a;
  localparam logic [31:0] UNUSED_CODE  = 32'hffffffff;
  localparam logic [3:0]  REPLY_BYTES  = 4'hf;
  // status codes
  localparam logic [7:0]  STS_OK       = 8'h00;
  localparam logic [7:0]  STS_PACKET   = 8'hc1;
  localparam logic [7:0]  STS_SUM      = 8'hc2;
  localparam logic [7:0]  STS_ACCEPT   = 8'hc3;
  localparam logic [7:0]  STS_PARAM    = 8'hc4;
  localparam logic [7:0]  STS_ADDR     = 8'hd0;
  localparam logic [7:0]  STS_SECURE   = 8'hd1;
  localparam logic [7:0]  STS_PROTECT  = 8'hd2;
  localparam logic [7:0]  STS_FLASH    = 8'he1;
  // area table
  localparam int          NUM_AREAS    = 4;
  localparam int          AREA_W       = 2;
  localparam logic [7:0]  KIND_EXT     = 8'h02;
  localparam logic [1:0]  EXT0_AREA    = 2'h2;
  // lifecycle states in which erasing is allowed, one bit per state
  localparam logic [7:0]  ERASE_LC_MASK = 8'h0f;
endpackage

/* hdl/flash_erase_command_handler.sv */
// Overview of operation
// - command packet: start, length 9, 12h, addresses
// - addresses arrive most significant byte first
// - success reply 81h, length 0Ah, code 12h
// - failure reply uses code 92h with fields
// - discard bytes until command start byte
// - missing terminator or bad length: packet error
// - checksum mismatch gives checksum error
// - any check error: no erase, back idle
// - lifecycle forbidding erase: acceptance error
// - encrypted write without reset: acceptance error
// - start above end: parameter error
// - outside areas or mixed kinds: parameter error
// - zero or misaligned erase unit: parameter error
// - inaccessible boundary location: invalid address error
// - level zero, or one touching secure: error
// - permanently protected block in range: protection error
// - report only highest priority error
// - controller error: flash status and location
// - driver error: flash error with unused codes
// - whole range erased: OK reply, wait again
// - external flash: chip or per-sector driver
// - erase start to end by erase unit
// - ordinary block protection is ignored
module flash_erase_command_handler import erase_pkg::*; (
  input  wire logic                       sys_clk_i,
  input  wire logic                       resetn_i,
  input  wire logic                       rx_valid_i,
  input  wire logic [7:0]                 rx_data_i,
  input  wire logic                       tx_ready_i,
  output logic                            tx_valid_o,
  output logic [7:0]                      tx_data_o,
  input  wire logic [2:0]                 lifecycle_state_i,
  input  wire logic                       enc_write_no_reset_i,
  input  wire logic                       auth_level_zero_i,
  input  wire logic                       auth_level_one_i,
  input  wire logic [NUM_AREAS-1:0][31:0] area_lo_i,
  input  wire logic [NUM_AREAS-1:0][31:0] area_hi_i,
  input  wire logic [NUM_AREAS-1:0][7:0]  area_kind_i,
  input  wire logic [NUM_AREAS-1:0][31:0] erase_unit_i,
  input  wire logic [31:0]                access_lo_i,
  input  wire logic [31:0]                access_hi_i,
  input  wire logic [31:0]                secure_lo_i,
  input  wire logic [31:0]                secure_hi_i,
  input  wire logic [31:0]                perm_lo_i,
  input  wire logic [31:0]                perm_hi_i,
  output logic                            erase_req_o,
  output logic [31:0]                     erase_addr_o,
  input  wire logic                       erase_done_i,
  input  wire logic                       erase_err_i,
  input  wire logic [31:0]                flash_status_i,
  output logic                            drv_req_o,
  output logic                            drv_chip_o,
  output logic [31:0]                     drv_addr_o,
  input  wire logic                       drv_done_i,
  input  wire logic                       drv_err_i,
  output logic                            busy_o
);
  typedef enum logic [3:0] {
    S_IDLE, S_LENH, S_LENL, S_BODY, S_SUM, S_ETX,
    S_CHECK, S_ERASE, S_REPLY, S_DONE
  } state_t;

  typedef struct packed {
    state_t      st;
    logic [15:0] len;     // received length field
    logic [15:0] cnt;     // body bytes still to come
    logic [7:0]  sum;     // running byte sum
    logic [7:0]  cmd;     // command code
    logic [63:0] addr;    // start then end location
    logic        etx_bad; // terminator missing
    logic [31:0] cur;     // unit now being erased
    logic [31:0] erase_unit;     // erase unit of the area
    logic        ext;     // external flash area
    logic        chip;    // one chip-erase call
    logic [7:0]  sts;     // status to report
    logic [31:0] det;     // status detail
    logic [31:0] loc;     // failure location
  } st_t;

  st_t         q, d;
  frame_if     rf ();
  logic [7:0]  chk_sts; // parameter-stage verdict
  logic [31:0] chk_eau;
  logic        chk_ext;
  logic        chk_chip;
  logic [31:0] start_location;
  logic [31:0] ead;
  logic        last;    // current unit reaches end location
  logic        done;    // erase step finished
  logic        fail;    // erase step reported an error

  assign start_location = q.addr[63:32];
  assign ead = q.addr[31:0];
  // unit end compared, not next start, so top of memory cannot wrap
  assign last = (q.cur + q.erase_unit - 32'h1) >= ead;
  assign done = q.ext ? drv_done_i : erase_done_i;
  assign fail = q.ext ? drv_err_i : erase_err_i;

  range_checker u_chk (
    .sad_i             (start_location),
    .ead_i             (ead),
    .area_lo_i         (area_lo_i),
    .area_hi_i         (area_hi_i),
    .area_kind_i       (area_kind_i),
    .erase_unit_i      (erase_unit_i),
    .access_lo_i       (access_lo_i),
    .access_hi_i       (access_hi_i),
    .secure_lo_i       (secure_lo_i),
    .secure_hi_i       (secure_hi_i),
    .perm_lo_i         (perm_lo_i),
    .perm_hi_i         (perm_hi_i),
    .auth_level_zero_i (auth_level_zero_i),
    .auth_level_one_i  (auth_level_one_i),
    .sts_o             (chk_sts),
    .eau_o             (chk_eau),
    .ext_o             (chk_ext),
    .chip_o            (chk_chip)
  );

  reply_framer u_frm (
    .sys_clk_i  (sys_clk_i),
    .resetn_i   (resetn_i),
    .rf         (rf.snk),
    .tx_ready_i (tx_ready_i),
    .tx_valid_o (tx_valid_o),
    .tx_data_o  (tx_data_o)
  );

  // reply fields straight from registers
  assign rf.send = (q.st == S_REPLY);
  assign rf.res  = (q.sts == STS_OK) ? CMD_ERASE : RES_ERR;
  assign rf.sts  = q.sts;
  assign rf.det  = q.det;
  assign rf.loc  = q.loc;

  // erase handshakes are levels held until the done pulse
  assign erase_req_o  = (q.st == S_ERASE) && !q.ext;
  assign erase_addr_o = q.cur;
  assign drv_req_o    = (q.st == S_ERASE) && q.ext;
  assign drv_chip_o   = q.chip;
  assign drv_addr_o   = q.cur;
  assign busy_o       = (q.st != S_IDLE);

  // receive, check, erase, reply
  always_comb begin
    d = q;
    case (q.st)
      S_IDLE: begin
        // anything but a start byte is dropped
        if (rx_valid_i && rx_data_i == CMD_START) begin
          d.st      = S_LENH;
          d.cmd     = 8'h00;
          d.etx_bad = 1'b0;
        end
      end
      S_LENH: begin
        if (rx_valid_i) begin
          d.len[15:8] = rx_data_i;
          d.sum       = rx_data_i;
          d.st        = S_LENL;
        end
      end
      S_LENL: begin
        if (rx_valid_i) begin
          d.len[7:0] = rx_data_i;
          d.sum      = q.sum + rx_data_i;
          d.cnt      = {q.len[15:8], rx_data_i};
          // the received length sets how many body bytes follow
          d.st       = ({q.len[15:8], rx_data_i} == 16'h0) ? S_SUM
                                                          : S_BODY;
        end
      end
      S_BODY: begin
        if (rx_valid_i) begin
          d.sum = q.sum + rx_data_i;
          d.cnt = q.cnt - 16'h1;
          if (q.cnt == q.len) begin
            d.cmd = rx_data_i;
          end else begin
            // shifting in keeps the last eight bytes, high first
            d.addr = {q.addr[55:0], rx_data_i};
          end
          if (q.cnt == 16'h1) d.st = S_SUM;
        end
      end
      S_SUM: begin
        if (rx_valid_i) begin
          d.sum = q.sum + rx_data_i;
          d.st  = S_ETX;
        end
      end
      S_ETX: begin
        if (rx_valid_i) begin
          d.etx_bad = (rx_data_i != TERMINATOR);
          d.st      = S_CHECK;
        end
      end
      S_CHECK: begin
        // one verdict, highest priority first
        d.st  = S_REPLY;
        d.det = UNUSED_CODE;
        d.loc = UNUSED_CODE;
        if (q.etx_bad) begin
          d.sts = STS_PACKET;
        end else if (q.sum != 8'h00) begin
          d.sts = STS_SUM;
        end else if (q.len == 16'h0) begin
          d.sts = STS_PACKET;
        end else if (q.cmd != CMD_ERASE) begin
          // other commands belong to other handlers
          d.st = S_IDLE;
        end else if (q.len != CMD_LEN) begin
          d.sts = STS_PACKET;
        end else if (!ERASE_LC_MASK[lifecycle_state_i]) begin
          d.sts = STS_ACCEPT;
        end else if (enc_write_no_reset_i) begin
          d.sts = STS_ACCEPT;
        end else if (chk_sts != STS_OK) begin
          // rejected before any erase request
          d.sts = chk_sts;
        end else begin
          d.sts  = STS_OK;
          d.st   = S_ERASE;
          d.cur  = start_location;
          d.erase_unit  = chk_eau;
          d.ext  = chk_ext;
          d.chip = chk_chip;
        end
      end
      S_ERASE: begin
        if (done) begin
          if (fail) begin
            d.st  = S_REPLY;
            d.sts = STS_FLASH;
            // driver faults carry no detail
            d.det = q.ext ? UNUSED_CODE : flash_status_i;
            d.loc = q.ext ? UNUSED_CODE : q.cur;
          end else if (q.chip || last) begin
            d.st = S_REPLY;
          end else begin
            d.cur = q.cur + q.erase_unit;
          end
        end
      end
      S_REPLY: begin
        d.st = S_DONE;
      end
      S_DONE: begin
        // bytes arriving during the reply are dropped
        if (!rf.busy) d.st = S_IDLE;
      end
      default: begin
        d.st = S_IDLE;
      end
    endcase
  end

  // single state register
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q     <= '0;
      q.st  <= S_IDLE;
      q.det <= UNUSED_CODE;
      q.loc <= UNUSED_CODE;
    end else begin
      q <= d;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_etx_bad;
    q.st == S_ETX && rx_valid_i && rx_data_i != TERMINATOR;
  endsequence
  sequence s_etx_ok_sum_bad;
    q.st == S_ETX && rx_valid_i && rx_data_i == TERMINATOR
      && q.sum != 8'h00;
  endsequence
  sequence s_step_ok;
    q.st == S_ERASE && done && !fail && !q.chip && !last;
  endsequence

  idle_discard_a: assert property (
    (q.st == S_IDLE && rx_valid_i && rx_data_i != CMD_START)
      |=> q.st == S_IDLE)
    else $error("non-start byte left the idle state");
  etx_missing_a: assert property (
    s_etx_bad |-> ##2 (rf.send && rf.sts == STS_PACKET))
    else $error("missing terminator not reported as packet error");
  sum_error_a: assert property (
    s_etx_ok_sum_bad |-> ##2 (rf.send && rf.sts == STS_SUM))
    else $error("bad checksum not reported");
  reject_no_erase_a: assert property (
    (q.st == S_CHECK && d.st == S_REPLY)
      |=> !erase_req_o && !drv_req_o ##1 q.st == S_DONE)
    else $error("erase requested after a rejected command");
  ok_reply_a: assert property (
    (rf.send && rf.sts == STS_OK) |-> (rf.res == CMD_ERASE
      && rf.det == UNUSED_CODE && rf.loc == UNUSED_CODE))
    else $error("success reply fields wrong");
  err_reply_a: assert property (
    (rf.send && rf.sts != STS_OK) |-> rf.res == RES_ERR)
    else $error("failure reply code wrong");
  flash_fault_a: assert property (
    (erase_req_o && erase_done_i && erase_err_i) |=> (rf.send
      && rf.sts == STS_FLASH && rf.loc == $past(erase_addr_o)
      && rf.det == $past(flash_status_i)))
    else $error("controller fault not reported with location");
  drv_fault_a: assert property (
    (drv_req_o && drv_done_i && drv_err_i) |=> (rf.send
      && rf.sts == STS_FLASH && rf.loc == UNUSED_CODE))
    else $error("driver fault not reported with unused codes");
  step_unit_a: assert property (
    s_step_ok |=> (q.st == S_ERASE
      && erase_addr_o == $past(erase_addr_o) + q.erase_unit))
    else $error("erase did not advance by one unit");
  range_done_a: assert property (
    (q.st == S_ERASE && done && !fail && (q.chip || last))
      |=> (rf.send && rf.sts == STS_OK))
    else $error("completed erase not answered with OK");
endmodule // flash_erase_command_handler

/* hdl/frame_if.sv */
interface frame_if;
  logic        send;  // one-cycle request to emit a status packet
  logic [7:0]  res;   // reply code
  logic [7:0]  sts;   // status code
  logic [31:0] det;   // status detail
  logic [31:0] loc;   // failure location
  logic        busy;  // framer still shifting out
  modport src (output send, res, sts, det, loc, input busy);
  modport snk (input send, res, sts, det, loc, output busy);
endinterface

/* hdl/range_checker.sv */
module range_checker import erase_pkg::*; (
  input  wire logic [31:0]                sad_i,
  input  wire logic [31:0]                ead_i,
  input  wire logic [NUM_AREAS-1:0][31:0] area_lo_i,
  input  wire logic [NUM_AREAS-1:0][31:0] area_hi_i,
  input  wire logic [NUM_AREAS-1:0][7:0]  area_kind_i,
  input  wire logic [NUM_AREAS-1:0][31:0] erase_unit_i,
  input  wire logic [31:0]                access_lo_i,
  input  wire logic [31:0]                access_hi_i,
  input  wire logic [31:0]                secure_lo_i,
  input  wire logic [31:0]                secure_hi_i,
  input  wire logic [31:0]                perm_lo_i,
  input  wire logic [31:0]                perm_hi_i,
  input  wire logic                       auth_level_zero_i,
  input  wire logic                       auth_level_one_i,
  output logic [7:0]                      sts_o,
  output logic [31:0]                     eau_o,
  output logic                            ext_o,
  output logic                            chip_o
);
  logic [NUM_AREAS-1:0] hit_s;  // start location inside area
  logic [NUM_AREAS-1:0] hit_e;  // end location inside area
  logic [AREA_W-1:0]    is_q;   // area of start
  logic [AREA_W-1:0]    ie;     // area of end
  logic [31:0]          mask;   // erase unit minus one
  logic [31:0]          ead_p1; // first byte past the range

  // one comparator pair per area
  for (genvar gi = 0; gi < NUM_AREAS; gi++) begin : g_area
    assign hit_s[gi] = sad_i >= area_lo_i[gi] && sad_i <= area_hi_i[gi];
    assign hit_e[gi] = ead_i >= area_lo_i[gi] && ead_i <= area_hi_i[gi];
  end

  // lowest matching area wins; errors in descending priority
  always_comb begin
    is_q = '0;
    ie   = '0;
    for (int i = NUM_AREAS - 1; i >= 0; i--) begin
      if (hit_s[i]) is_q = AREA_W'(i);
      if (hit_e[i]) ie = AREA_W'(i);
    end
    eau_o  = erase_unit_i[is_q];
    mask   = eau_o - 32'h1;
    ead_p1 = ead_i + 32'h1;
    ext_o  = (area_kind_i[is_q] == KIND_EXT);
    // whole of external area 0 goes to the chip-erase driver
    chip_o = ext_o && is_q == EXT0_AREA && sad_i == area_lo_i[is_q]
             && ead_i == area_hi_i[is_q];
    sts_o  = STS_OK;
    if (sad_i > ead_i) begin
      sts_o = STS_PARAM;
    end else if (hit_s == '0 || hit_e == '0) begin
      sts_o = STS_PARAM;
    end else if (area_kind_i[is_q] != area_kind_i[ie]) begin
      sts_o = STS_PARAM;
    end else if (eau_o == 32'h0) begin
      sts_o = STS_PARAM;
    end else if ((sad_i & mask) != 32'h0 || (ead_p1 & mask) != 32'h0) begin
      sts_o = STS_PARAM;
    end else if (sad_i < access_lo_i || ead_i > access_hi_i) begin
      sts_o = STS_ADDR;
    end else if (auth_level_zero_i || (auth_level_one_i
               && sad_i <= secure_hi_i && ead_i >= secure_lo_i)) begin
      sts_o = STS_SECURE;
    end else if (sad_i <= perm_hi_i && ead_i >= perm_lo_i) begin
      // only permanent protection counts here
      sts_o = STS_PROTECT;
    end
  end
endmodule // range_checker

/* hdl/reply_framer.sv */
module reply_framer import erase_pkg::*; (
  input  wire logic       sys_clk_i,
  input  wire logic       resetn_i,
  frame_if.snk            rf,
  input  wire logic       tx_ready_i,
  output logic            tx_valid_o,
  output logic [7:0]      tx_data_o
);
  typedef struct packed {
    logic [119:0] sh;   // fifteen bytes still to send, first in top lane
    logic [3:0]   cnt;  // bytes left
  } fr_t;

  fr_t        q, d;
  logic [7:0] acc;      // byte sum of length through location

  // load a whole packet at once, then shift a byte per accepted beat
  always_comb begin
    d   = q;
    acc = REPLY_LEN[15:8] + REPLY_LEN[7:0] + rf.res + rf.sts;
    for (int i = 0; i < 4; i++) begin
      acc = acc + rf.det[8*i +: 8] + rf.loc[8*i +: 8];
    end
    if (rf.send && q.cnt == 4'h0) begin
      // checksum makes length..sum add to zero
      d.sh  = {DATA_START, REPLY_LEN, rf.res, rf.sts, rf.det, rf.loc,
               8'h00 - acc, TERMINATOR};
      d.cnt = REPLY_BYTES;
    end else if (q.cnt != 4'h0 && tx_ready_i) begin
      d.sh  = {q.sh[111:0], 8'h00};
      d.cnt = q.cnt - 4'h1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rf.busy    = (q.cnt != 4'h0);
  assign tx_valid_o = (q.cnt != 4'h0);
  assign tx_data_o  = q.sh[119:112];

  // every status packet opens with the data start and ends terminated
  frame_ends_a: assert property (
    @(posedge sys_clk_i) disable iff (!resetn_i)
    (tx_valid_o && q.cnt == 4'h1) |-> tx_data_o == TERMINATOR)
    else $error("status packet does not end with terminator");
  frame_opens_a: assert property (
    @(posedge sys_clk_i) disable iff (!resetn_i)
    (rf.send && q.cnt == 4'h0) |=> (tx_data_o == DATA_START
      && q.cnt == REPLY_BYTES))
    else $error("status packet does not open with data start");
endmodule // reply_framer
